// File: flip_host_model.sv
// Host controller model: issues feature reads on the core clock.
// Assumes the bench drives everything else at the falling edge.
`timescale 1ns/100ps
module flip_host_model (
  input  wire logic       core_clk,
  input  wire logic       feat_rd_valid,
  input  wire logic [7:0] feat_rd_data,
  output logic            feat_rd_en,
  output logic      [7:0] feat_addr
);
  initial begin
    feat_rd_en = 1'b0;
    feat_addr  = 8'hA5;
  end
  // Only feature reads are issued, also while busy
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    feat_rd_en = 1'b1;
    feat_addr  = a;
    @(negedge core_clk);
    feat_rd_en = 1'b0;
    // Released address shows garbage so a stale value cannot hide a fault
    feat_addr = ~a;
    d = feat_rd_valid ? feat_rd_data : 8'hXX;
  endtask
endmodule // flip_host_model

// File: flip_report_chk_sva.sv
// Checker for the worst bit-flip report core, watching top ports only.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/100ps
module flip_report_chk
  import flip_report_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic       ecc_enable,
  input wire logic       feat_rd_en,
  input wire logic [7:0] feat_addr,
  input wire logic [7:0] feat_rd_data,
  input wire logic       feat_rd_valid,
  input wire logic       op_start,
  input wire logic       op_is_erase,
  input wire logic       block_invalid,
  input wire logic       array_done,
  input wire logic       op_launch,
  input wire logic       op_launch_erase,
  input wire logic       op_busy,
  input wire logic       program_fail_flag,
  input wire logic       erase_fail_flag,
  input wire logic       prog_valid,
  input wire logic       parity_valid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  chk_read_answer: assert property (feat_rd_en |=> feat_rd_valid)
    else $error("feature read not answered");
  chk_valid_cause: assert property (feat_rd_valid |-> $past(feat_rd_en))
    else $error("read valid without request");
  chk_unmapped_zero: assert property (feat_rd_en && feat_addr != FEAT_ADDR_REPORT
    && feat_addr != FEAT_ADDR_STATUS |=> feat_rd_data == 8'h00)
    else $error("unmapped read not zero");
  chk_count_code: assert property (feat_rd_en && feat_addr == FEAT_ADDR_REPORT
    |=> feat_rd_data[7:4] <= 4'h8 || feat_rd_data[7:4] == 4'hF)
    else $error("illegal count code");
  chk_report_gap: assert property (feat_rd_en && feat_addr == FEAT_ADDR_REPORT
    |=> !feat_rd_data[3])
    else $error("report bit 3 set");
  chk_prog_invalid: assert property (op_start && !op_busy && block_invalid
    && !op_is_erase |=> !op_launch && program_fail_flag)
    else $error("invalid block program not refused");
  chk_erase_invalid: assert property (op_start && !op_busy && block_invalid
    && op_is_erase |=> !op_launch && erase_fail_flag)
    else $error("invalid block erase not refused");
  chk_valid_launch: assert property (op_start && !op_busy && !block_invalid
    |=> op_launch && op_busy && op_launch_erase == $past(op_is_erase))
    else $error("valid operation not launched");
  chk_busy_release: assert property (op_busy && array_done |=> !op_busy)
    else $error("busy held after done");
  chk_parity_cause: assert property (parity_valid |-> $past(prog_valid)
    && $past(ecc_enable))
    else $error("parity without byte");
  cover property (feat_rd_en && feat_addr == FEAT_ADDR_REPORT);
  cover property (op_launch_erase);
  cover property (parity_valid);
endmodule // flip_report_chk
bind flip_report_core flip_report_chk u_chk (.*);

// File: flip_report_core.sv
// Worst bit-flip report, program/erase fail flags and sector parity of a
// serial NAND device with internal ECC.
// Assumes the command decoder and array engine run on core_clk and give
// one-cycle strobes; no input needs synchronising.
//
// Notes on behaviour
// - Worst sector flip count readable at 30h.
// - Count codes 0, 1..8 corrected, F uncorrected.
// - Bits 2:0 give worst sector number.
// - Ties report the lowest numbered sector.
// - Invalid block program/erase ignored, fail flag set.
// - Parity over 512 main plus 16 spare.
`timescale 1ns/100ps
module flip_report_core
  import flip_report_pkg::*;
(
  input  wire logic                                         core_clk,
  input  wire logic                                         sys_rst,
  input  wire logic                                         ecc_enable,
  input  wire logic                                         page_read_done,
  input  wire logic [flip_report_pkg::FLIPS_FLAT_WIDTH-1:0] sector_flips,
  input  wire logic                                         feat_rd_en,
  input  wire logic [7:0]                                   feat_addr,
  output logic      [7:0]                                   feat_rd_data,
  output logic                                              feat_rd_valid,
  input  wire logic                                         op_start,
  input  wire logic                                         op_is_erase,
  input  wire logic                                         block_invalid,
  input  wire logic                                         array_done,
  input  wire logic                                         array_fail,
  output logic                                              op_launch,
  output logic                                              op_launch_erase,
  output logic                                              op_busy,
  output logic                                              program_fail_flag,
  output logic                                              erase_fail_flag,
  input  wire logic                                         prog_valid,
  input  wire logic                                         prog_first,
  input  wire logic [7:0]                                   prog_data,
  output logic                                              parity_valid,
  output logic      [flip_report_pkg::PARITY_WIDTH-1:0]     parity_word
);
  import flip_report_pkg::*;

  flip_scan_if scan_bus ();

  assign scan_bus.sector_flips = sector_flips;

  worst_sector_scan u_scan (
    .scan (scan_bus.scanner)
  );

  // Report register
  logic [7:0] report_q;
  logic [7:0] report_d;

  always_comb begin
    report_d = report_q;
    // Held between ECC reads so a slow host still sees a coherent pair
    if (page_read_done && ecc_enable) begin
      report_d = 8'h00;
      report_d[REPORT_COUNT_MSB:REPORT_COUNT_LSB]   = scan_bus.worst_count;
      report_d[REPORT_SECTOR_MSB:REPORT_SECTOR_LSB] = scan_bus.worst_sector;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      report_q <= REPORT_RESET;
    end else begin
      report_q <= report_d;
    end
  end

  // Operation gate and fail flags
  logic busy_q;
  logic busy_d;
  logic launch_q;
  logic launch_d;
  logic launch_erase_q;
  logic launch_erase_d;
  logic kind_erase_q;
  logic kind_erase_d;
  logic prog_fail_q;
  logic prog_fail_d;
  logic erase_fail_q;
  logic erase_fail_d;
  logic accept_op;

  // A second start while busy is dropped; the host should not send one
  assign accept_op = op_start && !busy_q;

  always_comb begin
    busy_d         = busy_q;
    launch_d       = 1'b0;
    launch_erase_d = 1'b0;
    kind_erase_d   = kind_erase_q;
    prog_fail_d    = prog_fail_q;
    erase_fail_d   = erase_fail_q;
    if (busy_q && array_done) begin
      busy_d = 1'b0;
    end
    if (accept_op) begin
      kind_erase_d = op_is_erase;
      if (op_is_erase) begin
        erase_fail_d = 1'b0;
      end else begin
        prog_fail_d = 1'b0;
      end
      if (!block_invalid) begin
        busy_d         = 1'b1;
        launch_d       = 1'b1;
        launch_erase_d = op_is_erase;
      end
    end
    // Sets come last so an event in a clearing cycle is never lost
    if (accept_op && block_invalid) begin
      if (op_is_erase) begin
        erase_fail_d = 1'b1;
      end else begin
        prog_fail_d = 1'b1;
      end
    end
    if (busy_q && array_done && array_fail) begin
      if (kind_erase_q) begin
        erase_fail_d = 1'b1;
      end else begin
        prog_fail_d = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      busy_q         <= 1'b0;
      launch_q       <= 1'b0;
      launch_erase_q <= 1'b0;
      kind_erase_q   <= 1'b0;
      prog_fail_q    <= 1'b0;
      erase_fail_q   <= 1'b0;
    end else begin
      busy_q         <= busy_d;
      launch_q       <= launch_d;
      launch_erase_q <= launch_erase_d;
      kind_erase_q   <= kind_erase_d;
      prog_fail_q    <= prog_fail_d;
      erase_fail_q   <= erase_fail_d;
    end
  end

  // Feature read port
  logic [7:0] rd_data_q;
  logic [7:0] rd_data_d;
  logic       rd_valid_q;
  logic       rd_valid_d;
  logic [7:0] status_word;

  always_comb begin
    status_word                     = 8'h00;
    status_word[STATUS_BUSY_BIT]    = busy_q;
    status_word[STATUS_ERASE_BIT]   = erase_fail_q;
    status_word[STATUS_PROGRAM_BIT] = prog_fail_q;
  end

  always_comb begin
    rd_data_d  = rd_data_q;
    rd_valid_d = 1'b0;
    if (feat_rd_en) begin
      rd_valid_d = 1'b1;
      case (feat_addr)
        FEAT_ADDR_REPORT: rd_data_d = report_q;
        FEAT_ADDR_STATUS: rd_data_d = status_word;
        default:          rd_data_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rd_data_q  <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      rd_data_q  <= rd_data_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  // Sector parity over main plus spare bytes
  logic [BYTE_COUNT_WIDTH-1:0] byte_cnt_q;
  logic [BYTE_COUNT_WIDTH-1:0] byte_cnt_d;
  logic [PARITY_WIDTH-1:0]     parity_acc_q;
  logic [PARITY_WIDTH-1:0]     parity_acc_d;
  logic [PARITY_WIDTH-1:0]     parity_out_q;
  logic [PARITY_WIDTH-1:0]     parity_out_d;
  logic                        parity_valid_q;
  logic                        parity_valid_d;
  logic [BYTE_COUNT_WIDTH-1:0] index_now;
  logic [PARITY_WIDTH-1:0]     acc_base;
  logic [PARITY_WIDTH-1:0]     acc_next;

  // A sector start restarts the count, so a skipped column cannot skew it
  assign index_now = prog_first ? '0 : byte_cnt_q;
  assign acc_base  = prog_first ? PARITY_RESET : parity_acc_q;
  assign acc_next  = {acc_base[PARITY_WIDTH-2:0], acc_base[PARITY_WIDTH-1]}
                     ^ {8'h00, prog_data};

  always_comb begin
    byte_cnt_d     = byte_cnt_q;
    parity_acc_d   = parity_acc_q;
    parity_out_d   = parity_out_q;
    parity_valid_d = 1'b0;
    // Parity is only built with ECC on; with it off the area is user data
    if (prog_valid && ecc_enable) begin
      if (index_now == LAST_BYTE_INDEX) begin
        byte_cnt_d     = '0;
        parity_acc_d   = PARITY_RESET;
        parity_out_d   = acc_next;
        parity_valid_d = 1'b1;
      end else begin
        byte_cnt_d   = index_now + BYTE_COUNT_WIDTH'(1);
        parity_acc_d = acc_next;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      byte_cnt_q     <= '0;
      parity_acc_q   <= PARITY_RESET;
      parity_out_q   <= PARITY_RESET;
      parity_valid_q <= 1'b0;
    end else begin
      byte_cnt_q     <= byte_cnt_d;
      parity_acc_q   <= parity_acc_d;
      parity_out_q   <= parity_out_d;
      parity_valid_q <= parity_valid_d;
    end
  end

  assign feat_rd_data      = rd_data_q;
  assign feat_rd_valid     = rd_valid_q;
  assign op_launch         = launch_q;
  assign op_launch_erase   = launch_erase_q;
  assign op_busy           = busy_q;
  assign program_fail_flag = prog_fail_q;
  assign erase_fail_flag   = erase_fail_q;
  assign parity_valid      = parity_valid_q;
  assign parity_word       = parity_out_q;
endmodule // flip_report_core

// File: flip_report_pkg.sv
// Constants for the worst bit-flip report, fail flags and sector parity.
// Assumes one core clock; all users import the whole package.
package flip_report_pkg;
  localparam int unsigned SECTOR_COUNT       = 8;
  localparam int unsigned FLIP_WIDTH         = 4;
  localparam int unsigned SECTOR_WIDTH       = 3;
  localparam int unsigned FLIPS_FLAT_WIDTH   = SECTOR_COUNT * FLIP_WIDTH;
  localparam logic [3:0]  FLIP_NONE          = 4'h0;
  localparam logic [3:0]  FLIP_MAX_CORRECTED = 4'h8;
  localparam logic [3:0]  FLIP_UNCORRECTED   = 4'hF;
  localparam logic [7:0]  FEAT_ADDR_REPORT   = 8'h30;
  localparam logic [7:0]  FEAT_ADDR_STATUS   = 8'hC0;
  localparam int unsigned REPORT_COUNT_MSB   = 7;
  localparam int unsigned REPORT_COUNT_LSB   = 4;
  localparam int unsigned REPORT_SECTOR_MSB  = 2;
  localparam int unsigned REPORT_SECTOR_LSB  = 0;
  localparam logic [7:0]  REPORT_RESET       = 8'h00;
  localparam int unsigned STATUS_BUSY_BIT    = 0;
  localparam int unsigned STATUS_ERASE_BIT   = 2;
  localparam int unsigned STATUS_PROGRAM_BIT = 3;
  localparam int unsigned SECTOR_MAIN_BYTES  = 512;
  localparam int unsigned SECTOR_SPARE_BYTES = 16;
  localparam int unsigned SECTOR_BYTES       = SECTOR_MAIN_BYTES + SECTOR_SPARE_BYTES;
  localparam int unsigned BYTE_COUNT_WIDTH   = 10;
  localparam logic [9:0]  LAST_BYTE_INDEX    = 10'(SECTOR_BYTES - 1);
  localparam int unsigned PARITY_WIDTH       = 16;
  localparam logic [15:0] PARITY_RESET       = 16'h0000;
endpackage

// File: flip_scan_if.sv
// Carries per-sector flip counts to the scanner and the worst result back.
// Assumes both ends share the core clock domain.
`timescale 1ns/100ps
interface flip_scan_if;
  import flip_report_pkg::*;
  logic [FLIPS_FLAT_WIDTH-1:0] sector_flips;
  logic [FLIP_WIDTH-1:0]       worst_count;
  logic [SECTOR_WIDTH-1:0]     worst_sector;
  modport scanner (input sector_flips, output worst_count, output worst_sector);
  modport user    (output sector_flips, input worst_count, input worst_sector);
endinterface

// File: tb_nand_ecc_report_and_command_rules.sv
// Self-checking bench for the worst bit-flip report core.
// Assumes inputs change at the falling edge; host model does reads.
`timescale 1ns/100ps
module tb_nand_ecc_report_and_command_rules;
  import flip_report_pkg::*;
  logic core_clk = 0, sys_rst = 1, ecc_enable = 0, page_read_done = 0;
  logic [31:0] sector_flips = 32'h0;
  logic op_start = 0, op_is_erase = 0, block_invalid = 0;
  logic array_done = 0, array_fail = 0, prog_valid = 0, prog_first = 0;
  logic [7:0] prog_data = 8'h00, feat_addr, feat_rd_data, d;
  logic feat_rd_en, feat_rd_valid, op_launch, op_launch_erase, op_busy;
  logic program_fail_flag, erase_fail_flag, parity_valid;
  logic [15:0] parity_word, p;
  int errors = 0, n_compared = 0;
  localparam logic [39:0] ROWS [5] = '{{32'h0000_0000, 8'h00}, {32'h0505_0000, 8'h54},
    {32'h8F00_0008, 8'hF6}, {32'h1111_1111, 8'h10}, {32'hF0F0_0000, 8'hF5}};
  flip_report_core u_dut (.*);
  flip_host_model u_host (.*);
  initial forever #5 core_clk = ~core_clk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic page(input logic [31:0] f, input logic en);
    @(negedge core_clk);
    ecc_enable     = en;
    sector_flips   = f;
    page_read_done = 1'b1;
    @(negedge core_clk);
    page_read_done = 1'b0;
    sector_flips   = ~f;
  endtask
  task automatic op(input logic er, input logic inv);
    @(negedge core_clk);
    op_start      = 1'b1;
    op_is_erase   = er;
    block_invalid = inv;
    @(negedge core_clk);
    op_start      = 1'b0;
    block_invalid = ~inv;
  endtask
  task automatic finish_op(input logic fail);
    @(negedge core_clk);
    array_done = 1'b1;
    array_fail = fail;
    @(negedge core_clk);
    array_done = 1'b0;
    array_fail = 1'b0;
  endtask
  initial begin
    #100us;
    errors++;
    complete_run();
  end
  initial begin
    repeat (4) @(negedge core_clk);
    sys_rst = 1'b0;
    u_host.rd(FEAT_ADDR_REPORT, d);
    chk({8'h00, d}, 16'h0000);
    u_host.rd(FEAT_ADDR_STATUS, d);
    chk({8'h00, d}, 16'h0000);
    $display("test reset done");
    for (int c = 1; c <= 8; c++) begin
      page(32'(c) << (4 * (c - 1)), 1'b1);
      u_host.rd(FEAT_ADDR_REPORT, d);
      chk({8'h00, d}, {8'h00, 4'(c), 1'b0, 3'(c - 1)});
    end
    foreach (ROWS[i]) begin
      page(ROWS[i][39:8], 1'b1);
      u_host.rd(FEAT_ADDR_REPORT, d);
      chk({8'h00, d}, {8'h00, ROWS[i][7:0]});
    end
    $display("test report rows done");
    // ECC off page read must not disturb the last report
    page(32'h0000_0007, 1'b0);
    u_host.rd(FEAT_ADDR_REPORT, d);
    chk({8'h00, d}, 16'h00F5);
    u_host.rd(8'h55, d);
    chk({8'h00, d}, 16'h0000);
    $display("test hold and unmapped done");
    op(1'b0, 1'b0);
    chk({op_launch, op_launch_erase, op_busy}, 16'h0005);
    u_host.rd(FEAT_ADDR_STATUS, d);
    chk({8'h00, d}, 16'h0001);
    finish_op(1'b1);
    // The same status read serves as the check after a failed program
    u_host.rd(FEAT_ADDR_STATUS, d);
    chk({8'h00, d}, 16'h0008);
    chk({program_fail_flag, erase_fail_flag}, 16'h0002);
    // Only an initial invalid block is targeted, never a detected bad one
    // Bad means its marker column read 00; such blocks are never erased
    op(1'b1, 1'b1);
    chk({op_launch, op_busy}, 16'h0000);
    u_host.rd(FEAT_ADDR_STATUS, d);
    chk({8'h00, d}, 16'h000C);
    op(1'b1, 1'b0);
    chk({op_launch, op_launch_erase}, 16'h0003);
    finish_op(1'b0);
    u_host.rd(FEAT_ADDR_STATUS, d);
    chk({8'h00, d}, 16'h0008);
    $display("test operations done");
    // Main and spare bytes of one sector go in one load
    // A cut load is restarted, as after a random-data column skip
    // Bytes go in ascending column order within the page
    for (int i = -5; i < 528; i++) begin
      @(negedge core_clk);
      ecc_enable = 1'b1;
      prog_valid = 1'b1;
      prog_first = (i == -5) || (i == 0);
      prog_data  = 8'(i) ^ 8'h3C;
      if (i == 0) begin
        p = 16'h0000;
      end
      p = {p[14:0], p[15]} ^ {8'h00, prog_data};
    end
    @(negedge core_clk);
    prog_valid = 1'b0;
    for (int i = 0; i < 4 && parity_valid !== 1'b1; i++) @(negedge core_clk);
    chk({15'h0, parity_valid}, 16'h0001);
    chk(parity_word, p);
    $display("test parity done");
    @(negedge core_clk);
    sys_rst = 1'b1;
    @(negedge core_clk);
    sys_rst = 1'b0;
    chk({program_fail_flag, erase_fail_flag, op_busy}, 16'h0000);
    u_host.rd(FEAT_ADDR_REPORT, d);
    chk({8'h00, d}, 16'h0000);
    $display("test mid-run reset done");
    complete_run();
  end
endmodule // tb_nand_ecc_report_and_command_rules

// File: worst_sector_scan.sv
// Combinational search for the sector with the largest flip count.
// Assumes counts arrive already encoded, with F for uncorrectable.
`timescale 1ns/100ps
module worst_sector_scan
  import flip_report_pkg::*;
(
  flip_scan_if.scanner scan
);
  import flip_report_pkg::*;

  logic [FLIP_WIDTH-1:0]   best_count  [SECTOR_COUNT];
  logic [SECTOR_WIDTH-1:0] best_sector [SECTOR_COUNT];

  assign best_count[0]  = scan.sector_flips[FLIP_WIDTH-1:0];
  assign best_sector[0] = '0;

  // F sorts above 1..8, so uncorrectable sectors win as plain numbers
  for (genvar i = 1; i < SECTOR_COUNT; i++) begin : g_chain
    logic [FLIP_WIDTH-1:0] this_count;
    assign this_count = scan.sector_flips[i*FLIP_WIDTH +: FLIP_WIDTH];
    // Strictly greater only, so a tie keeps the earlier sector
    assign best_count[i]  = (this_count > best_count[i-1]) ? this_count : best_count[i-1];
    assign best_sector[i] = (this_count > best_count[i-1]) ? SECTOR_WIDTH'(i)
                                                            : best_sector[i-1];
  end

  assign scan.worst_count  = best_count[SECTOR_COUNT-1];
  assign scan.worst_sector = best_sector[SECTOR_COUNT-1];
endmodule // worst_sector_scan
